// ---- design/pfs_core.sv ----
// Program counter, return stack, indirect pointers and context shadows
//
// How it works
// - The return stack holds 16 entries of 15 bits each.
// - A push onto a full stack sets the overflow flag and a pop from an empty one the underflow flag.
// - With the stack-error reset option on, either stack error also forces a software reset.
// - The program counter is 15 bits wide, a 32K-word space of 14-bit words.
// - Addresses above 07FFh wrap into the 2,048 implemented words rather than faulting.
// - Execution starts at 0000h after reset and jumps to 0004h on an accepted interrupt.
// - The range 0780h-07FFh is the high-endurance area, flagged whenever it is read as bytes.
// - Two independent 16-bit pointers reach data memory and program memory in one space.
// - An indirect read that targets program memory takes one extra cycle to fetch the word.
// - Pointers offer a linear view of general RAM spanning banks of 80 bytes.
// - Interrupt entry copies the core context into shadows and the interrupt return restores it.
// - The decoder belongs to a 49-instruction set and resolves the flow and pointer ones here.
// - Direct, indirect-through-pointer and PC-relative addressing are all supported.
// - Pointer bit 15 selects program memory and a read returns the low byte of the word.
// - Writes through the indirect port to program memory are dropped.
`timescale 1ns/1ps
`default_nettype none

module pfs_core (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [6:0]  pclath,
  input  wire logic [7:0]  wreg,
  input  wire logic        irq_req,
  input  wire logic        stk_rst_en,
  input  wire logic        ovf_clr,
  input  wire logic        unf_clr,
  input  wire logic        ptr_wr,
  input  wire logic        ptr_wr_sel,
  input  wire logic [15:0] ptr_wr_data,
  input  wire logic [13:0] pm_rdata,
  input  wire logic [31:0] ctx_in,
  output logic [14:0]      pc_r,
  output logic [14:0]      fetch_addr_r,
  output logic             stall_r,
  output logic             soft_reset_r,
  output logic             stack_overflow_flag_r,
  output logic             stack_underflow_flag_r,
  output logic [4:0]       stack_depth_r,
  output logic [15:0]      ptr0,
  output logic [15:0]      ptr1,
  output logic [14:0]      ind_addr_r,
  output logic             ind_pm_r,
  output logic             ind_rd_r,
  output logic             ind_wr_r,
  output logic [7:0]       ind_wdata_r,
  output logic [7:0]       pm_byte_r,
  output logic             pm_byte_vld_r,
  output logic             he_area_r,
  output logic             int_active_r,
  output logic [31:0]      ctx_out_r,
  output logic             ctx_restore_r
);

  // ----------------------------------------------------------------
  // Decode and address mapping functions
  // ----------------------------------------------------------------

  // Only flow and pointer instructions matter here; the rest run in sequence
  function automatic pfs_pkg::pfs_cls_t pfs_decode(input logic [13:0] op);
    pfs_pkg::pfs_cls_t c;
    c = pfs_pkg::CLS_SEQ;
    if (op[13:11] == pfs_pkg::PFX_CALL)       c = pfs_pkg::CLS_CALL;
    else if (op[13:11] == pfs_pkg::PFX_GOTO)  c = pfs_pkg::CLS_GOTO;
    else if (op[13:8] == pfs_pkg::PFX_RETLW)  c = pfs_pkg::CLS_RET;
    else if (op[13:9] == pfs_pkg::PFX_BRA)    c = pfs_pkg::CLS_BRA;
    else if (op[13:7] == pfs_pkg::PFX_MOVRK)  c = pfs_pkg::CLS_MOVI_K;
    else if (op[13:7] == pfs_pkg::PFX_MOVWK)  c = pfs_pkg::CLS_MOVI_K;
    else if (op[13:7] == pfs_pkg::PFX_ADDF)   c = pfs_pkg::CLS_ADDFSR;
    else if (op[13:4] == pfs_pkg::PFX_MOVIM)  c = pfs_pkg::CLS_MOVI_M;
    else if (op == pfs_pkg::OP_RETURN)        c = pfs_pkg::CLS_RET;
    else if (op == pfs_pkg::OP_RETFIE)        c = pfs_pkg::CLS_RETFIE;
    else if (op == pfs_pkg::OP_CALLW)         c = pfs_pkg::CLS_CALLW;
    else if (op == pfs_pkg::OP_BRW)           c = pfs_pkg::CLS_BRW;
    else if (op == pfs_pkg::OP_RESET)         c = pfs_pkg::CLS_RESET;
    return c;
  endfunction : pfs_decode

  // Maps a pointer value onto a program or data address
  function automatic logic [14:0] pfs_map(input logic [15:0] p);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] idx;
    off  = p - pfs_pkg::LIN_BASE;
    bank = off / pfs_pkg::GPR_BANK_LEN;
    idx  = (off % pfs_pkg::GPR_BANK_LEN) + pfs_pkg::GPR_BANK_OFS;
    if (p[pfs_pkg::PTR_PM_BIT])
      pfs_map = p[14:0] & pfs_pkg::PM_MASK;
    else if (p <= pfs_pkg::TRAD_LAST)
      pfs_map = {3'h0, p[11:0]};
    else if (p <= pfs_pkg::LIN_LAST)
      pfs_map = {3'h0, bank[4:0], idx[6:0]};
    else
      pfs_map = 15'h0000; // Unimplemented space maps to address 0000h
  endfunction : pfs_map

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  pfs_pkg::pfs_state_t state_r;
  pfs_pkg::pfs_state_t state_nxt;
  logic [14:0]         stk_r [pfs_pkg::STK_DEPTH];
  logic [15:0]         ptr_r [2];
  logic [15:0]         ptr_sh_r [2];
  logic [31:0]         ctx_sh_r;

  pfs_pkg::pfs_cls_t cls;
  logic              exec;
  logic              irq_take;
  logic              push_req;
  logic              pop_req;
  logic [14:0]       push_val;
  logic [14:0]       pc_inc;
  logic [14:0]       pc_nxt;
  logic              ovf_evt;
  logic              unf_evt;
  logic              stk_err_rst;
  logic              ind_acc;
  logic              ind_write;
  logic              ind_sel;
  logic [15:0]       ptr_old;
  logic [15:0]       ptr_new;
  logic [15:0]       ptr_eff;
  logic [14:0]       ind_map;
  logic              ptr_upd;

  assign ptr0 = ptr_r[0];
  assign ptr1 = ptr_r[1];

  // ----------------------------------------------------------------
  // Instruction steering
  // ----------------------------------------------------------------

  // Interrupts are taken only between instructions and never nest
  assign cls      = pfs_decode(instr);
  assign exec     = instr_valid && (state_r == pfs_pkg::ST_RUN);
  assign irq_take = exec && irq_req && !int_active_r;
  assign pc_inc   = pc_r + pfs_pkg::PC_ONE;

  // Stack requests and their error events
  always_comb begin
    push_req = 1'b0;
    pop_req  = 1'b0;
    push_val = pc_inc;
    if (irq_take) begin
      push_req = 1'b1;
      push_val = pc_r; // Interrupted instruction is re-run on return
    end else if (exec) begin
      push_req = (cls == pfs_pkg::CLS_CALL) || (cls == pfs_pkg::CLS_CALLW);
      pop_req  = (cls == pfs_pkg::CLS_RET) || (cls == pfs_pkg::CLS_RETFIE);
    end
  end

  assign ovf_evt     = push_req && (stack_depth_r == 5'(pfs_pkg::STK_DEPTH));
  assign unf_evt     = pop_req && (stack_depth_r == 5'h00);
  assign stk_err_rst = stk_rst_en && (ovf_evt || unf_evt);

  // Next program counter
  always_comb begin
    pc_nxt = pc_r;
    if (state_r == pfs_pkg::ST_SRST) begin
      pc_nxt = pfs_pkg::RESET_VEC;
    end else if (irq_take) begin
      pc_nxt = pfs_pkg::INT_VEC;
    end else if (exec) begin
      case (cls)
        pfs_pkg::CLS_CALL,
        pfs_pkg::CLS_GOTO:   pc_nxt = {pclath[6:3], instr[10:0]};
        pfs_pkg::CLS_CALLW:  pc_nxt = {pclath, wreg};
        pfs_pkg::CLS_RET,
        pfs_pkg::CLS_RETFIE: pc_nxt = unf_evt ? pc_inc : stk_r[4'(stack_depth_r - 5'h01)];
        pfs_pkg::CLS_BRA:    pc_nxt = pc_inc + {{6{instr[8]}}, instr[8:0]};
        pfs_pkg::CLS_BRW:    pc_nxt = pc_inc + {7'h00, wreg};
        default:             pc_nxt = pc_inc;
      endcase
    end
  end

  // Indirect access through a pointer, with pre/post modify or offset
  always_comb begin
    ind_acc   = exec && !irq_take &&
                ((cls == pfs_pkg::CLS_MOVI_M) || (cls == pfs_pkg::CLS_MOVI_K));
    ind_sel   = (cls == pfs_pkg::CLS_MOVI_M) ? instr[2] : instr[6];
    ind_write = (cls == pfs_pkg::CLS_MOVI_M) ? instr[3] : instr[7];
    ptr_old   = ptr_r[ind_sel];
    ptr_new   = ptr_old;
    ptr_eff   = ptr_old;
    ptr_upd   = 1'b0;
    if (cls == pfs_pkg::CLS_MOVI_M) begin
      ptr_new = ptr_old + (instr[0] ? pfs_pkg::PTR_DEC : pfs_pkg::PTR_INC);
      ptr_eff = instr[1] ? ptr_old : ptr_new;
      ptr_upd = ind_acc;
    end else if (cls == pfs_pkg::CLS_MOVI_K) begin
      ptr_eff = ptr_old + {{10{instr[5]}}, instr[5:0]};
    end else if (cls == pfs_pkg::CLS_ADDFSR) begin
      ptr_new = ptr_old + {{10{instr[5]}}, instr[5:0]};
      ptr_upd = exec && !irq_take;
    end
    ind_map = pfs_map(ptr_eff);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Program-memory reads park here one cycle while the word arrives
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pfs_pkg::ST_RUN: begin
        if (stk_err_rst || (exec && !irq_take && cls == pfs_pkg::CLS_RESET))
          state_nxt = pfs_pkg::ST_SRST;
        else if (ind_acc && !ind_write && ptr_eff[pfs_pkg::PTR_PM_BIT])
          state_nxt = pfs_pkg::ST_PMRD;
      end
      pfs_pkg::ST_PMRD: state_nxt = pfs_pkg::ST_RUN;
      pfs_pkg::ST_SRST: state_nxt = pfs_pkg::ST_RUN;
      default:          state_nxt = pfs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r      <= pfs_pkg::ST_RUN;
      stall_r      <= 1'b0;
      soft_reset_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      stall_r      <= (state_nxt != pfs_pkg::ST_RUN);
      soft_reset_r <= (state_nxt == pfs_pkg::ST_SRST);
    end
  end

  // Program counter and wrapped fetch address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_r         <= pfs_pkg::RESET_VEC;
      fetch_addr_r <= pfs_pkg::RESET_VEC;
    end else begin
      pc_r         <= pc_nxt;
      fetch_addr_r <= pc_nxt & pfs_pkg::PM_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------

  // A push on a full stack is dropped so that older return addresses survive
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stack_depth_r <= 5'h00;
    end else if (state_r == pfs_pkg::ST_SRST) begin
      stack_depth_r <= 5'h00;
    end else if (push_req && !ovf_evt) begin
      stack_depth_r <= stack_depth_r + 5'h01;
    end else if (pop_req && !unf_evt) begin
      stack_depth_r <= stack_depth_r - 5'h01;
    end
  end

  generate
    for (genvar e = 0; e < pfs_pkg::STK_DEPTH; e++) begin : g_stk
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
          stk_r[e] <= 15'h0000;
        else if (push_req && !ovf_evt && stack_depth_r[3:0] == 4'(e))
          stk_r[e] <= push_val;
      end
    end
  endgenerate

  // Error flags survive a soft reset so software can read the cause
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stack_overflow_flag_r  <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
    end else begin
      if (ovf_evt)
        stack_overflow_flag_r <= 1'b1;
      else if (ovf_clr)
        stack_overflow_flag_r <= 1'b0;
      if (unf_evt)
        stack_underflow_flag_r <= 1'b1;
      else if (unf_clr)
        stack_underflow_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Indirect pointers and their shadows
  // ----------------------------------------------------------------

  // A port load wins over an instruction update in the same cycle
  generate
    for (genvar g = 0; g < 2; g++) begin : g_ptr
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          ptr_r[g]    <= 16'h0000;
          ptr_sh_r[g] <= 16'h0000;
        end else if (state_r == pfs_pkg::ST_SRST) begin
          ptr_r[g]    <= 16'h0000;
        end else begin
          if (irq_take)
            ptr_sh_r[g] <= ptr_r[g];
          if (ptr_wr && ptr_wr_sel == 1'(g))
            ptr_r[g] <= ptr_wr_data;
          else if (exec && !irq_take && cls == pfs_pkg::CLS_RETFIE)
            ptr_r[g] <= ptr_sh_r[g];
          else if (ptr_upd && ind_sel == 1'(g))
            ptr_r[g] <= ptr_new;
        end
      end
    end
  endgenerate

  // Indirect port strobes; program memory is read-only through this path
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ind_addr_r  <= 15'h0000;
      ind_pm_r    <= 1'b0;
      ind_rd_r    <= 1'b0;
      ind_wr_r    <= 1'b0;
      ind_wdata_r <= 8'h00;
      he_area_r   <= 1'b0;
    end else begin
      ind_rd_r <= ind_acc && !ind_write && !ptr_eff[pfs_pkg::PTR_PM_BIT];
      ind_wr_r <= ind_acc && ind_write && !ptr_eff[pfs_pkg::PTR_PM_BIT];
      if (ind_acc) begin
        ind_addr_r  <= ind_map;
        ind_pm_r    <= ptr_eff[pfs_pkg::PTR_PM_BIT];
        ind_wdata_r <= wreg;
        he_area_r   <= ptr_eff[pfs_pkg::PTR_PM_BIT] && !ind_write &&
                       (ind_map >= pfs_pkg::HE_FIRST) && (ind_map <= pfs_pkg::HE_LAST);
      end
    end
  end

  // Byte captured from the program word after the extra cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pm_byte_r     <= 8'h00;
      pm_byte_vld_r <= 1'b0;
    end else begin
      pm_byte_vld_r <= (state_r == pfs_pkg::ST_PMRD);
      if (state_r == pfs_pkg::ST_PMRD)
        pm_byte_r <= pm_rdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt context
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_active_r  <= 1'b0;
      ctx_sh_r      <= 32'h0000_0000;
      ctx_out_r     <= 32'h0000_0000;
      ctx_restore_r <= 1'b0;
    end else begin
      ctx_restore_r <= exec && !irq_take && cls == pfs_pkg::CLS_RETFIE;
      if (state_r == pfs_pkg::ST_SRST) begin
        int_active_r <= 1'b0;
      end else if (irq_take) begin
        int_active_r <= 1'b1;
        ctx_sh_r     <= ctx_in;
      end else if (exec && cls == pfs_pkg::CLS_RETFIE) begin
        int_active_r <= 1'b0;
        ctx_out_r    <= ctx_sh_r;
      end
    end
  end

endmodule : pfs_core

`default_nettype wire

// ---- design/pfs_pkg.sv ----
// Constants, encodings and types for the program-flow and stack core
package pfs_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W        = 15;
  localparam int INSTR_W     = 14;
  localparam int STK_DEPTH   = 16;
  localparam int STK_PTR_W   = 5;
  localparam int PTR_W       = 16;
  localparam int CTX_W       = 32;
  localparam int INSTR_COUNT = 49;

  // ----------------------------------------------------------------
  // Program memory map
  // ----------------------------------------------------------------
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC   = 15'h0004;
  localparam logic [14:0] PM_MASK   = 15'h07FF;
  localparam logic [14:0] HE_FIRST  = 15'h0780;
  localparam logic [14:0] HE_LAST   = 15'h07FF;
  localparam logic [14:0] PC_ONE    = 15'h0001;

  // ----------------------------------------------------------------
  // Pointer space
  // ----------------------------------------------------------------
  localparam int          PTR_PM_BIT   = 15;
  localparam logic [15:0] TRAD_LAST    = 16'h0FFF;
  localparam logic [15:0] LIN_BASE     = 16'h2000;
  localparam logic [15:0] LIN_LAST     = 16'h29AF;
  localparam logic [15:0] GPR_BANK_LEN = 16'h0050;
  localparam logic [15:0] GPR_BANK_OFS = 16'h0020;
  localparam logic [15:0] PTR_INC      = 16'h0001;
  localparam logic [15:0] PTR_DEC      = 16'hFFFF;

  // ----------------------------------------------------------------
  // Instruction encodings used by the flow and pointer decoder
  // ----------------------------------------------------------------
  localparam logic [13:0] OP_RESET  = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFIE = 14'h0009;
  localparam logic [13:0] OP_CALLW  = 14'h000A;
  localparam logic [13:0] OP_BRW    = 14'h000B;
  localparam logic [2:0]  PFX_CALL  = 3'h4;
  localparam logic [2:0]  PFX_GOTO  = 3'h5;
  localparam logic [5:0]  PFX_RETLW = 6'h34;
  localparam logic [4:0]  PFX_BRA   = 5'h19;
  localparam logic [9:0]  PFX_MOVIM = 10'h001;
  localparam logic [6:0]  PFX_MOVRK = 7'h7E;
  localparam logic [6:0]  PFX_MOVWK = 7'h7F;
  localparam logic [6:0]  PFX_ADDF  = 7'h62;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_PMRD = 3'b010,
    ST_SRST = 3'b100
  } pfs_state_t;

  typedef enum logic [3:0] {
    CLS_SEQ    = 4'h0,
    CLS_CALL   = 4'h1,
    CLS_GOTO   = 4'h2,
    CLS_CALLW  = 4'h3,
    CLS_RET    = 4'h4,
    CLS_RETFIE = 4'h5,
    CLS_BRA    = 4'h6,
    CLS_BRW    = 4'h7,
    CLS_RESET  = 4'h8,
    CLS_MOVI_M = 4'h9,
    CLS_MOVI_K = 4'hA,
    CLS_ADDFSR = 4'hB
  } pfs_cls_t;

endpackage : pfs_pkg

// ---- sim/pfs_core_chk.sv ----
// Concurrent checks on the program-flow core ports
`timescale 1ns/1ps
`default_nettype none
module pfs_core_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic [6:0]  pclath,
  input wire logic        irq_req,
  input wire logic        stk_rst_en,
  input wire logic [13:0] pm_rdata,
  input wire logic [14:0] pc_r,
  input wire logic [14:0] fetch_addr_r,
  input wire logic        stall_r,
  input wire logic        soft_reset_r,
  input wire logic        stack_overflow_flag_r,
  input wire logic        stack_underflow_flag_r,
  input wire logic [4:0]  stack_depth_r,
  input wire logic [14:0] ind_addr_r,
  input wire logic        ind_pm_r,
  input wire logic        ind_wr_r,
  input wire logic [7:0]  pm_byte_r,
  input wire logic        pm_byte_vld_r,
  input wire logic        he_area_r,
  input wire logic        int_active_r
);
  // ------------
  // Decode
  // ------------
  // An instruction counts only when no fresh interrupt replaces it
  logic go;
  logic is_call;
  logic is_ret;
  assign go = instr_valid && !stall_r && !(irq_req && !int_active_r);
  assign is_call = go && (instr[13:11] == pfs_pkg::PFX_CALL);
  assign is_ret = go && (instr == pfs_pkg::OP_RETURN);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------------
  // Properties
  // ------------
  a_stack_bound: assert property (stack_depth_r <= 5'h10)
    else $error("stack depth beyond sixteen");
  a_call_push: assert property (is_call && stack_depth_r < 5'h10 |=>
    pc_r == {$past(pclath[6:3]), $past(instr[10:0])}
    && stack_depth_r == $past(stack_depth_r) + 5'h01)
    else $error("call target or depth wrong");
  a_fetch_wrap: assert property (fetch_addr_r == (pc_r & pfs_pkg::PM_MASK))
    else $error("fetch address not wrapped");
  a_int_vector: assert property (instr_valid && irq_req && !int_active_r
    && !stall_r && stack_depth_r < 5'h10 |=> pc_r == pfs_pkg::INT_VEC && int_active_r)
    else $error("interrupt vector not taken");
  a_ovf_flag: assert property (is_call && stack_depth_r == 5'h10 |=>
    stack_overflow_flag_r && stack_depth_r == 5'h10)
    else $error("overflow not flagged");
  a_unf_flag: assert property (is_ret && stack_depth_r == 5'h00 |=> stack_underflow_flag_r)
    else $error("underflow not flagged");
  a_err_reset: assert property (is_ret && stack_depth_r == 5'h00 && stk_rst_en |=>
    soft_reset_r && stall_r ##1 !soft_reset_r && pc_r == pfs_pkg::RESET_VEC
    && stack_depth_r == 5'h00)
    else $error("stack error reset missing");
  a_pm_byte: assert property (pm_byte_vld_r |->
    $past(stall_r) && !stall_r && pm_byte_r == $past(pm_rdata[7:0]))
    else $error("program byte wrong or late");
  a_pm_no_write: assert property (ind_wr_r |-> !ind_pm_r)
    else $error("write strobe toward program memory");
  a_he_window: assert property (pm_byte_vld_r |->
    he_area_r == (ind_addr_r >= pfs_pkg::HE_FIRST && ind_addr_r <= pfs_pkg::HE_LAST))
    else $error("endurance window flag wrong");
endmodule : pfs_core_chk

bind pfs_core pfs_core_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
  .pclath(pclath), .irq_req(irq_req), .stk_rst_en(stk_rst_en), .pm_rdata(pm_rdata),
  .pc_r(pc_r), .fetch_addr_r(fetch_addr_r), .stall_r(stall_r),
  .soft_reset_r(soft_reset_r), .stack_overflow_flag_r(stack_overflow_flag_r),
  .stack_underflow_flag_r(stack_underflow_flag_r), .stack_depth_r(stack_depth_r),
  .ind_addr_r(ind_addr_r), .ind_pm_r(ind_pm_r), .ind_wr_r(ind_wr_r),
  .pm_byte_r(pm_byte_r), .pm_byte_vld_r(pm_byte_vld_r), .he_area_r(he_area_r),
  .int_active_r(int_active_r)
);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking testbench for the program-flow core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------
  // Signals and model state
  // ------------
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [6:0]  pclath = 7'h00;
  logic [7:0]  wreg = 8'h00;
  logic        irq_req = 1'b0;
  logic        stk_rst_en = 1'b0;
  logic        ovf_clr = 1'b0;
  logic        unf_clr = 1'b0;
  logic        ptr_wr = 1'b0;
  logic        ptr_wr_sel = 1'b0;
  logic [15:0] ptr_wr_data = 16'h0000;
  logic [13:0] pm_rdata = 14'h0000;
  logic [31:0] ctx_in = 32'h0000_0000;
  logic [14:0] pc_r, fetch_addr_r, ind_addr_r;
  logic        stall_r, soft_reset_r, stack_overflow_flag_r, stack_underflow_flag_r;
  logic [4:0]  stack_depth_r;
  logic [15:0] ptr0, ptr1;
  logic        ind_pm_r, ind_rd_r, ind_wr_r, pm_byte_vld_r, he_area_r;
  logic        int_active_r, ctx_restore_r;
  logic [7:0]  ind_wdata_r, pm_byte_r;
  logic [31:0] ctx_out_r;
  int          stk[$];
  int          pc = 0;
  int          err_count = 0;
  int          checks = 0;
  integer      seed = 32'h7972;
  int          i;
  int          p;
  int          a;
  logic [31:0] v;

  // Free-running system clock
  always #50 clk_sys = ~clk_sys;

  pfs_core dut (
    .clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .pclath(pclath), .wreg(wreg), .irq_req(irq_req), .stk_rst_en(stk_rst_en),
    .ovf_clr(ovf_clr), .unf_clr(unf_clr), .ptr_wr(ptr_wr), .ptr_wr_sel(ptr_wr_sel),
    .ptr_wr_data(ptr_wr_data), .pm_rdata(pm_rdata), .ctx_in(ctx_in), .pc_r(pc_r),
    .fetch_addr_r(fetch_addr_r), .stall_r(stall_r), .soft_reset_r(soft_reset_r),
    .stack_overflow_flag_r(stack_overflow_flag_r),
    .stack_underflow_flag_r(stack_underflow_flag_r), .stack_depth_r(stack_depth_r),
    .ptr0(ptr0), .ptr1(ptr1), .ind_addr_r(ind_addr_r), .ind_pm_r(ind_pm_r),
    .ind_rd_r(ind_rd_r), .ind_wr_r(ind_wr_r), .ind_wdata_r(ind_wdata_r),
    .pm_byte_r(pm_byte_r), .pm_byte_vld_r(pm_byte_vld_r), .he_area_r(he_area_r),
    .int_active_r(int_active_r), .ctx_out_r(ctx_out_r), .ctx_restore_r(ctx_restore_r)
  );

  // ------------
  // Helpers
  // ------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Logical counter wraps at 15 bits, not at the implemented size
  function automatic int nx(input int q);
    return (q + 1) & 32'h7FFF;
  endfunction : nx

  // One instruction per call; an idle cycle follows so strobes never merge
  task automatic exe(input logic [13:0] w);
    @(negedge clk_sys);
    instr = w;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask : exe

  task automatic ldp(input logic s, input logic [15:0] d);
    @(negedge clk_sys);
    ptr_wr_sel = s;
    ptr_wr_data = d;
    ptr_wr = 1'b1;
    @(negedge clk_sys);
    ptr_wr = 1'b0;
  endtask : ldp

  task automatic pcchk;
    chk("pc", pc_r, pc);
    chk("fetch", fetch_addr_r, pc & 32'h7FF);
    chk("depth", stack_depth_r, stk.size());
  endtask : pcchk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #400000;
    err_count++;
    test_done;
  end

  // ------------
  // Test sequence
  // ------------
  initial begin
    repeat (8) @(negedge clk_sys);
    chk("reset pc", pc_r, 0);
    rstn = 1'b1;
    // Nest calls one past capacity with random far targets
    for (i = 0; i < 17; i++) begin
      v = $random(seed);
      pclath = v[6:0];
      if (i < 16) stk.push_back(nx(pc));
      if (i < 16) pc = {v[6:3], v[26:16]};
      exe({pfs_pkg::PFX_CALL, v[26:16]});
      if (i < 16) pcchk;
    end
    chk("ovf", stack_overflow_flag_r, 1);
    // Unwind one past empty, mixing both return kinds
    for (i = 0; i < 17; i++) begin
      exe(i[0] ? {pfs_pkg::PFX_RETLW, 8'h5A} : pfs_pkg::OP_RETURN);
      pc = (i < 16) ? stk.pop_back() : nx(pc);
      pcchk;
    end
    chk("unf", stack_underflow_flag_r, 1);
    @(negedge clk_sys);
    ovf_clr = 1'b1;
    unf_clr = 1'b1;
    @(negedge clk_sys);
    ovf_clr = 1'b0;
    unf_clr = 1'b0;
    chk("flags clear", {stack_overflow_flag_r, stack_underflow_flag_r}, 0);
    $display("test stack nesting done");
    // Underflow with the reset option on
    ldp(1'b0, 16'h1234);
    stk_rst_en = 1'b1;
    exe(pfs_pkg::OP_RETURN);
    chk("sreset", {stall_r, soft_reset_r, stack_underflow_flag_r}, 3'h7);
    @(negedge clk_sys);
    pc = 0;
    pcchk;
    chk("ptr after sreset", ptr0, 0);
    chk("sreset end", {stall_r, soft_reset_r}, 0);
    stk_rst_en = 1'b0;
    $display("test stack error reset done");
    // Interrupt entry, a refused second request, then return
    v = $random(seed);
    @(negedge clk_sys);
    ctx_in = v;
    irq_req = 1'b1;
    instr = 14'h0000;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    stk.push_back(pc);
    pc = 4;
    pcchk;
    chk("int active", int_active_r, 1);
    ctx_in = ~v;
    exe(14'h0000);
    pc = nx(pc);
    pcchk;
    irq_req = 1'b0;
    exe(pfs_pkg::OP_RETFIE);
    pc = stk.pop_back();
    pcchk;
    chk("ctx", ctx_out_r, v);
    chk("ctx strobe", {ctx_restore_r, int_active_r}, 2'h2);
    // Relative branches on random offsets, wrapping at 15 bits
    v = $random(seed);
    wreg = v[7:0];
    exe({pfs_pkg::PFX_BRA, v[16:8]});
    pc = (pc + 1 + {{23{v[16]}}, v[16:8]}) & 32'h7FFF;
    pcchk;
    exe(pfs_pkg::OP_BRW);
    pc = (pc + 1 + v[7:0]) & 32'h7FFF;
    pcchk;
    $display("test interrupt done");
    // Linear data accesses in all four pre/post modify modes, reads and writes
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      p = 16'h2001 + (v[15:0] % 16'h09AE);
      wreg = v[23:16];
      ldp(1'b1, p[15:0]);
      exe({pfs_pkg::PFX_MOVIM, i[2], 1'b1, i[1:0]});
      a = (i[1:0] == 0) ? p + 1 : (i[1:0] == 1) ? p - 1 : p;
      a = a - 16'h2000;
      chk("lin addr", ind_addr_r, (a / 80) * 128 + 32 + a % 80);
      chk("strobes", {ind_pm_r, ind_rd_r, ind_wr_r}, i[2] ? 3'h1 : 3'h2);
      chk("ptr1 step", ptr1, i[0] ? p - 1 : p + 1);
      if (i[2]) chk("wdata", ind_wdata_r, v[23:16]);
      pc = nx(pc);
      pcchk;
    end
    $display("test data pointer done");
    // Program-memory reads inside and outside the endurance window
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      a = {2'b10, v[13:0]};
      if (i[0]) a[10:7] = 4'hF;
      ldp(1'b0, a[15:0]);
      exe({pfs_pkg::PFX_MOVIM, 4'h2});
      chk("pm stall", {stall_r, ind_pm_r, pm_byte_vld_r}, 3'h6);
      chk("pm addr", ind_addr_r, a & 32'h7FF);
      pm_rdata = v[29:16];
      @(negedge clk_sys);
      chk("pm byte", pm_byte_r, v[23:16]);
      chk("pm done", {stall_r, pm_byte_vld_r}, 2'h1);
      chk("he area", he_area_r, a[10:7] == 4'hF);
      chk("ptr0 step", ptr0, (a + 1) & 32'hFFFF);
      pm_rdata = ~v[29:16];
      pc = nx(pc);
      pcchk;
      exe({pfs_pkg::PFX_MOVIM, 4'hA});
      chk("pm write", {ind_wr_r, ind_pm_r}, 2'h1);
      repeat (2) @(negedge clk_sys);
      pc = nx(pc);
    end
    $display("test program pointer done");
    test_done;
  end
endmodule : tb_top
`default_nettype wire
